// file: rtl/gpio_fg.sv
// Purpose: Two-port GPIO (three-pin port F, two-pin port G with pull-ups)
// Assumes: Classic Wishbone slave; pins asynchronous to ref_clk_in, synchronised in two stages
// Notes:   Answers every access one cycle after the request
// Operation
// - Direction one drives latch value out
// - Direction zero leaves pin undriven
// - Latch write shows on output pins
// - Latch written for inputs, pin stays undriven
// - Output pins read back latch
// - Input pins read pin; RMW reads latch
// - Pin read even when peripheral uses it
// - Reset clears all direction bits
// - Float on standby: Hi-Z, input held low
// - No float: standby keeps pins unchanged
// - Port G pull-up bit connects pull-up
// - Pull-up off while pin driven low
// - Open-drain output high means Hi-Z
// - Port F bits 0..2 only
// - Port G bits 1..2 only
// - Variant makes port F pin 2 reset only
`timescale 1ns/10ps
`include "gpio_fg_params.svh"

module gpio_fg #(
  parameter logic [7:0] OPEN_DRAIN_F = `OPEN_DRAIN_F, // Open-drain pins of port F
  parameter logic [7:0] OPEN_DRAIN_G = `OPEN_DRAIN_G  // Open-drain pins of port G
) (
  input  wire logic        ref_clk_in,       // 200 MHz system clock
  input  wire logic        rst_n_in,         // Synchronous CPU reset, active low
  input  wire logic        wb_cyc_in,        // Wishbone cycle
  input  wire logic        wb_stb_in,        // Wishbone strobe
  input  wire logic        wb_we_in,         // Wishbone write enable
  input  wire logic [7:0]  wb_adr_in,        // Wishbone byte address
  input  wire logic [3:0]  wb_sel_in,        // Wishbone byte selects
  input  wire logic [31:0] wb_dat_in,        // Wishbone write data
  output logic [31:0]      wb_dat_out,       // Wishbone read data
  output logic             wb_ack_out,       // Wishbone acknowledge
  input  wire logic        rmw_read_in,      // Current read is RMW kind
  input  wire logic        stop_mode_in,     // Device is in stop mode
  input  wire logic        watch_mode_in,    // Device is in watch mode
  input  wire logic [7:0]  port_f_pin_in,    // Port F pad levels
  output logic [7:0]       port_f_pin_out,   // Port F pad drive values
  output logic [7:0]       port_f_pin_oe_out,// Port F pad drive enables
  output logic [7:0]       port_f_int_out,   // Port F internal input to peripherals
  input  wire logic [7:0]  port_g_pin_in,    // Port G pad levels
  output logic [7:0]       port_g_pin_out,   // Port G pad drive values
  output logic [7:0]       port_g_pin_oe_out,// Port G pad drive enables
  output logic [7:0]       port_g_pullup_out,// Port G pull-up connects
  output logic [7:0]       port_g_int_out    // Port G internal input to peripherals
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] port_f_output_latch_r;  // Port F latch
  logic [7:0] port_f_direction_r;     // Port F direction
  logic [7:0] port_g_output_latch_r;  // Port G latch
  logic [7:0] port_g_direction_r;     // Port G direction
  logic [7:0] port_g_pullup_enable_r; // Port G pull-up enables
  logic [7:0] standby_control_reg_r;  // Float, stop, watch-by-software bits
  logic       reset_pin_variant_r;    // Port F pin 2 is reset only
  logic [7:0] f_meta_r, f_sync_r;     // Port F synchroniser stages
  logic [7:0] g_meta_r, g_sync_r;     // Port G synchroniser stages
  gpio_fg_pkg::bus_state_t bus_state_r; // Bus answer state
  logic [31:0] rd_data_nxt;           // Read mux output
  logic       req;                    // New request this cycle
  logic       wr_en;                  // Write taken this cycle
  logic       standby_float;          // Pins forced to float
  logic [7:0] f_mask;                 // Port F usable pins

  ////////////////////////////////////////////////////////////////////////////
  // Read-back merge, used for both ports
  function automatic logic [7:0] port_read(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input logic [7:0] pins,
    input logic       rmw,
    input logic [7:0] mask
  );
    logic [7:0] merged;
    merged = rmw ? latch : ((dir & latch) | (~dir & pins));
    return merged & mask;
  endfunction : port_read

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign req   = wb_cyc_in && wb_stb_in && (bus_state_r == gpio_fg_pkg::BUS_IDLE);
  // Write lands on the edge where the master samples ack, not the taking edge,
  // so a master that aborts before ack never changes a register
  assign wr_en = wb_cyc_in && wb_stb_in && (bus_state_r == gpio_fg_pkg::BUS_ACK) &&
                 wb_we_in && wb_sel_in[0];
  // Reset-only pin removed from the usable set
  assign f_mask = `PORT_F_MASK & ~{5'h00, reset_pin_variant_r, 2'h0};
  // Float only when enabled and a low-power mode is entered
  assign standby_float = standby_control_reg_r[`STBY_FLOAT_BIT] &&
                         (stop_mode_in || watch_mode_in ||
                          standby_control_reg_r[`STBY_STOP_BIT] ||
                          standby_control_reg_r[`STBY_WATCH_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // Answer one cycle after request; ack drops the next cycle
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      bus_state_r <= gpio_fg_pkg::BUS_IDLE;
    end else begin
      case (bus_state_r)
        gpio_fg_pkg::BUS_IDLE: begin
          if (req) begin
            bus_state_r <= gpio_fg_pkg::BUS_ACK;
          end
        end
        gpio_fg_pkg::BUS_ACK:  bus_state_r <= gpio_fg_pkg::BUS_IDLE;
        default:               bus_state_r <= gpio_fg_pkg::BUS_IDLE;
      endcase
    end
  end
  assign wb_ack_out = (bus_state_r == gpio_fg_pkg::BUS_ACK);

  ////////////////////////////////////////////////////////////////////////////
  // Direction registers, cleared by CPU reset
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      port_f_direction_r <= `DIR_RESET;
      port_g_direction_r <= `DIR_RESET;
    end else if (wr_en) begin
      if (wb_adr_in == `ADDR_PORT_F_DIR) begin
        port_f_direction_r <= wb_dat_in[7:0] & `PORT_F_MASK;
      end
      if (wb_adr_in == `ADDR_PORT_G_DIR) begin
        port_g_direction_r <= wb_dat_in[7:0] & `PORT_G_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latches, written whatever the direction
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      port_f_output_latch_r <= `LATCH_RESET;
      port_g_output_latch_r <= `LATCH_RESET;
    end else if (wr_en) begin
      if (wb_adr_in == `ADDR_PORT_F_LATCH) begin
        port_f_output_latch_r <= wb_dat_in[7:0] & `PORT_F_MASK;
      end
      if (wb_adr_in == `ADDR_PORT_G_LATCH) begin
        port_g_output_latch_r <= wb_dat_in[7:0] & `PORT_G_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull-up enables, standby control and variant strap
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      port_g_pullup_enable_r <= `PULLUP_RESET;
      standby_control_reg_r  <= 8'h00;
      reset_pin_variant_r    <= 1'b0;
    end else if (wr_en) begin
      if (wb_adr_in == `ADDR_PORT_G_PULLUP) begin
        port_g_pullup_enable_r <= wb_dat_in[7:0] & `PORT_G_MASK;
      end
      if (wb_adr_in == `ADDR_STANDBY_CTRL) begin
        standby_control_reg_r <= wb_dat_in[7:0] & `STBY_MASK;
      end
      if (wb_adr_in == `ADDR_VARIANT) begin
        reset_pin_variant_r <= wb_dat_in[`VARIANT_RST_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      f_meta_r <= 8'h00;
      f_sync_r <= 8'h00;
      g_meta_r <= 8'h00;
      g_sync_r <= 8'h00;
    end else begin
      f_meta_r <= port_f_pin_in;
      f_sync_r <= f_meta_r;
      g_meta_r <= port_g_pin_in;
      g_sync_r <= g_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_data_nxt = 32'h0000_0000;
    case (wb_adr_in)
      `ADDR_PORT_F_LATCH:  rd_data_nxt[7:0] = port_read(port_f_output_latch_r,
                             port_f_direction_r, f_sync_r, rmw_read_in, f_mask);
      `ADDR_PORT_F_DIR:    rd_data_nxt[7:0] = port_f_direction_r;
      `ADDR_PORT_G_LATCH:  rd_data_nxt[7:0] = port_read(port_g_output_latch_r,
                             port_g_direction_r, g_sync_r, rmw_read_in, `PORT_G_MASK);
      `ADDR_PORT_G_DIR:    rd_data_nxt[7:0] = port_g_direction_r;
      `ADDR_PORT_G_PULLUP: rd_data_nxt[7:0] = port_g_pullup_enable_r;
      `ADDR_STANDBY_CTRL:  rd_data_nxt[7:0] = standby_control_reg_r;
      `ADDR_VARIANT:       rd_data_nxt[0]   = reset_pin_variant_r;
      default:             rd_data_nxt      = 32'h0000_0000;
    endcase
  end

  // Read data registered at request, held while ack stands
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (req && !wb_we_in) begin
      wb_dat_out <= rd_data_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive; combinational so a latch write shows at once
  // Open-drain high and standby float both release the pad
  always_comb begin
    port_f_pin_out    = port_f_output_latch_r & f_mask;
    port_f_pin_oe_out = port_f_direction_r & f_mask &
                        ~(OPEN_DRAIN_F & port_f_output_latch_r);
    port_g_pin_out    = port_g_output_latch_r & `PORT_G_MASK;
    port_g_pin_oe_out = port_g_direction_r & `PORT_G_MASK &
                        ~(OPEN_DRAIN_G & port_g_output_latch_r);
    if (standby_float) begin
      port_f_pin_oe_out = 8'h00;
      port_g_pin_oe_out = 8'h00;
    end
    // Pull-up released whenever the pad is driven low
    port_g_pullup_out = port_g_pullup_enable_r & `PORT_G_MASK &
                        ~(port_g_pin_oe_out & ~port_g_pin_out);
    // Internal input locked low to avoid leakage from a floating pad
    port_f_int_out = standby_float ? 8'h00 : (f_sync_r & f_mask);
    port_g_int_out = standby_float ? 8'h00 : (g_sync_r & `PORT_G_MASK);
  end

endmodule : gpio_fg

// file: rtl/gpio_fg_params.svh
// Purpose: Offsets, field positions and reset values for the two-port GPIO block
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef GPIO_FG_PARAMS_SVH
`define GPIO_FG_PARAMS_SVH

`define ADDR_PORT_F_LATCH   8'h00
`define ADDR_PORT_F_DIR     8'h04
`define ADDR_PORT_G_LATCH   8'h08
`define ADDR_PORT_G_DIR     8'h0C
`define ADDR_PORT_G_PULLUP  8'h10
`define ADDR_STANDBY_CTRL   8'h14
`define ADDR_VARIANT        8'h18

`define PORT_F_MASK         8'h07
`define PORT_G_MASK         8'h06
`define DIR_RESET           8'h00
`define LATCH_RESET         8'h00
`define PULLUP_RESET        8'h00
`define STBY_FLOAT_BIT      0
`define STBY_STOP_BIT       1
`define STBY_WATCH_BIT      2
`define STBY_MASK           8'h07
`define VARIANT_RST_BIT     0
`define OPEN_DRAIN_F        8'h00
`define OPEN_DRAIN_G        8'h00

`endif

// file: rtl/gpio_fg_pkg.sv
// Purpose: Types for the two-port GPIO block
// Assumes: Used with gpio_fg_params.svh
// Notes:   Nothing here holds a number
package gpio_fg_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;
endpackage : gpio_fg_pkg

// file: tb/gpio_fg_pads.sv
// Purpose: Pad model resolving drive, pull-up and outside level
// Assumes: Outside source is weak, overridden by drive or pull-up
// Notes:   Outside level is fresh random per pass, never a stale value
`timescale 1ns/10ps
module gpio_fg_pads (
  input  wire logic [7:0] out_in, // Drive values
  input  wire logic [7:0] oe_in,  // Drive enables
  input  wire logic [7:0] pu_in,  // Pull-up connects
  input  wire logic [7:0] ext_in, // Outside level
  output logic [7:0]      lvl_out // Resolved pad level
);
  // Undriven pins follow pull-up, else outside source
  // No peripheral output drives a pad here, as software must ensure
  assign lvl_out = (oe_in & out_in) | (~oe_in & pu_in) | (~oe_in & ~pu_in & ext_in);
endmodule : gpio_fg_pads

// file: tb/gpio_fg_sva.sv
// Purpose: Port-level assertions for the two-port GPIO block
// Assumes: Bound to gpio_fg, one clock, synchronous active-low reset
// Notes:   Sees ports only; register contents are judged by the bench
`timescale 1ns/10ps
module gpio_fg_sva (
  input wire logic        ref_clk_in,        // System clock
  input wire logic        rst_n_in,          // Reset, active low
  input wire logic        wb_cyc_in,         // Bus cycle
  input wire logic        wb_stb_in,         // Bus strobe
  input wire logic [31:0] wb_dat_out,        // Read data
  input wire logic        wb_ack_out,        // Acknowledge
  input wire logic        stop_mode_in,      // Stop mode
  input wire logic        watch_mode_in,     // Watch mode
  input wire logic [7:0]  port_f_pin_in,     // Port F pads
  input wire logic [7:0]  port_f_pin_oe_out, // Port F drive enables
  input wire logic [7:0]  port_f_int_out,    // Port F internal input
  input wire logic [7:0]  port_g_pin_out,    // Port G drive values
  input wire logic [7:0]  port_g_pin_oe_out, // Port G drive enables
  input wire logic [7:0]  port_g_pullup_out  // Port G pull-ups
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Mode inputs off; the synchroniser path is still gated if software sets float with its stop or watch bit
  logic run;                                 // Stop and watch mode inputs both low
  assign run = !stop_mode_in && !watch_mode_in;
  ack_pulse_a:   assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  ack_latency_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack not one cycle after request");
  f_mask_a:      assert property ((port_f_pin_oe_out & 8'hF8) == 8'h00)
    else $error("port f drives unimplemented pin");
  g_mask_a:      assert property ((port_g_pin_oe_out & 8'hF9) == 8'h00)
    else $error("port g drives unimplemented pin");
  pullup_low_a:  assert property ((port_g_pullup_out & port_g_pin_oe_out & ~port_g_pin_out) == 8'h00)
    else $error("pull-up on low driven pin");
  pullup_mask_a: assert property ((port_g_pullup_out & 8'hF9) == 8'h00)
    else $error("pull-up on unimplemented pin");
  read_hi_a:     assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  sync_lag_a:    assert property (run [*3] |-> port_f_int_out[1:0] == $past(port_f_pin_in[1:0], 2))
    else $error("pin level not two cycles late");
  // Main scenarios seen
  c_access: cover property ($rose(wb_ack_out));
  c_float:  cover property (stop_mode_in && port_f_pin_oe_out == 8'h00);
  c_pullup: cover property (port_g_pullup_out != 8'h00);
endmodule : gpio_fg_sva
bind gpio_fg gpio_fg_sva gpio_fg_sva_i (.ref_clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in,
  .wb_dat_out, .wb_ack_out, .stop_mode_in, .watch_mode_in, .port_f_pin_in, .port_f_pin_oe_out,
  .port_f_int_out, .port_g_pin_out, .port_g_pin_oe_out, .port_g_pullup_out);

// file: tb/gpio_fg_tb_top.sv
// Purpose: Self-checking bench for the two-port GPIO block
// Assumes: Port F pin 0 open drain in this build
// Notes:   Random register and pad values, fixed seed
`timescale 1ns/10ps
`include "gpio_fg_params.svh"
module gpio_fg_tb_top;
  logic clk = 1'b0, rst_n, cyc, stb, we, rmw, stop, watch, ack;
  logic [7:0]  adr, fpin, gpin, fext, gext, fo, foe, fint, go, goe, gpu, gint;
  logic [7:0]  fl, fd, gl, gd, gp, fe, ge, efo, ego, epu, elf, elg;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, rd;
  int          miscompares = 0, compares = 0;
  always #2.5 clk = ~clk;
  gpio_fg #(.OPEN_DRAIN_F(8'h01)) gpio_fg_i (.ref_clk_in(clk), .rst_n_in(rst_n),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(dat), .wb_dat_out(dat_o), .wb_ack_out(ack), .rmw_read_in(rmw),
    .stop_mode_in(stop), .watch_mode_in(watch), .port_f_pin_in(fpin), .port_f_pin_out(fo),
    .port_f_pin_oe_out(foe), .port_f_int_out(fint), .port_g_pin_in(gpin),
    .port_g_pin_out(go), .port_g_pin_oe_out(goe), .port_g_pullup_out(gpu),
    .port_g_int_out(gint));
  gpio_fg_pads pads_f_i (.out_in(fo), .oe_in(foe), .pu_in(8'h00), .ext_in(fext), .lvl_out(fpin));
  gpio_fg_pads pads_g_i (.out_in(go), .oe_in(goe), .pu_in(gpu), .ext_in(gext), .lvl_out(gpin));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One classic cycle; held until ack is sampled, then released for a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic r);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h000000, d}; rmw <= r;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic end_sim();
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the expected run of about eleven hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hF; dat = 32'h0;
    rmw = 1'b0; stop = 1'b0; watch = 1'b0; fext = 8'h00; gext = 8'h00;
    void'($urandom(32'hB3F8E2D4));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, `ADDR_PORT_F_DIR, 8'h00, 0); check("f dir", rd, 32'h0);
    bus(0, `ADDR_PORT_G_DIR, 8'h00, 0); check("g dir", rd, 32'h0);
    bus(0, 8'h1C, 8'h00, 0); check("unmapped", rd, 32'h0);
    for (int i = 0; i < 40; i++) begin
      {fl, fd, gl, gd} = $urandom; {gp, fe, ge} = $urandom;
      if (i == 0) {fl, fd, gl, gd, gp} = {8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF}; // Low with pull-up
      fext <= fe; gext <= ge;
      efo = fd & `PORT_F_MASK & ~(fl & 8'h01); ego = gd & `PORT_G_MASK;
      epu = gp & `PORT_G_MASK & ~(ego & ~gl);
      elf = (efo & fl) | (~efo & fe); elg = (ego & gl) | (~ego & epu) | (~ego & ~epu & ge);
      bus(1, `ADDR_PORT_F_LATCH, fl, 0); bus(1, `ADDR_PORT_F_DIR, fd, 0);
      bus(1, `ADDR_PORT_G_LATCH, gl, 0); bus(1, `ADDR_PORT_G_DIR, gd, 0);
      bus(1, `ADDR_PORT_G_PULLUP, gp, 0);
      check("f oe", foe, efo);
      check("f out", fo & efo, fl & efo);
      check("g oe", goe, ego);
      check("g out", go & ego, gl & ego);
      check("g pullup", gpu, epu);
      bus(0, `ADDR_PORT_F_LATCH, 8'h00, 0); check("f read", rd, ((fd & fl) | (~fd & elf)) & 8'h07);
      bus(0, `ADDR_PORT_F_LATCH, 8'h00, 1); check("f rmw", rd, fl & 8'h07);
      bus(0, `ADDR_PORT_G_LATCH, 8'h00, 0); check("g read", rd, ((gd & gl) | (~gd & elg)) & 8'h06);
      bus(0, `ADDR_PORT_G_LATCH, 8'h00, 1); check("g rmw", rd, gl & 8'h06);
    end
    bus(1, `ADDR_STANDBY_CTRL, 8'h01, 0); stop <= 1'b1; repeat (3) @(posedge clk);
    check("float oe", {foe, goe}, 16'h0000);
    check("float int", {fint, gint}, 16'h0000);
    bus(1, `ADDR_STANDBY_CTRL, 8'h00, 0); stop <= 1'b0; watch <= 1'b1; repeat (3) @(posedge clk);
    check("hold oe", {foe, goe}, {efo, ego});
    watch <= 1'b0;
    bus(1, `ADDR_VARIANT, 8'h01, 0); bus(1, `ADDR_PORT_F_DIR, 8'hFF, 0); bus(1, `ADDR_PORT_F_LATCH, 8'h00, 0);
    check("reset pin", foe, 8'h03);
    rst_n <= 1'b0; repeat (2) @(posedge clk);
    rst_n <= 1'b1; @(posedge clk);
    check("oe after reset", {foe, goe}, 16'h0000);
    bus(0, `ADDR_PORT_F_DIR, 8'h00, 0); check("f dir again", rd, 32'h0);
    end_sim();
  end
endmodule : gpio_fg_tb_top
